// [hw/crf_top.v]
// Programmer-visible register file of the processor core, with APB access
`timescale 1ns/1ns
`include "crf_defs.vh"

// Operation
// RQ1 - Four 16-bit data registers, usable as operands.
// RQ2 - First two data registers also split into separate bytes.
// RQ3 - Third over first, fourth over second: 32-bit data pairs.
// RQ4 - Two 16-bit address registers, for addressing and as operands.
// RQ5 - Second address register over first: 32-bit address pair.
// RQ6 - 16-bit frame base register for frame-relative addressing.
// RQ7 - 20-bit vector table base register.
// RQ8 - 20-bit program counter, next instruction address.
// RQ9 - 16-bit user and interrupt stack pointers; stack-select flag picks one.
// RQ10 - 16-bit static base register for static-relative addressing.
// RQ11 - Status flag register is 11 bits wide.
// RQ12 - Carry flag takes ALU carry, borrow or shift-out bit.
// RQ13 - Software keeps the debug flag at zero.
// RQ14 - Zero flag is 1 for a zero result, else 0.
// RQ15 - Sign flag is 1 for a negative result, else 0.
// RQ16 - Bank-select flag 0 picks bank 0, 1 picks bank 1.
// RQ17 - Overflow flag is 1 on overflow, else 0.
// RQ18 - Data, address and frame base registers banked; others single.

module crf_top
#(
    parameter [`CRF_PC_W-1:0] PC_RESET = `CRF_RST_ADDR20
)
(
    // Clock and reset
    input wire REF_CLK_I,
    input wire RST_N_I,
    // APB slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [`CRF_ADDR_W-1:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output reg [31:0] PRDATA_O,
    output reg PREADY_O,
    output reg PSLVERR_O,
    // Execution unit operand reads
    input wire [4:0] EU_RSEL_A_I,
    input wire [4:0] EU_RSEL_B_I,
    output reg [31:0] EU_OPA_O,
    output reg [31:0] EU_OPB_O,
    // Execution unit register write
    input wire EU_WE_I,
    input wire [4:0] EU_WSEL_I,
    input wire [31:0] EU_WDATA_I,
    // ALU flag update
    input wire ALU_FLAG_WE_I,
    input wire [3:0] ALU_FMASK_I,
    input wire [1:0] ALU_SIZE_I,
    input wire [31:0] ALU_RESULT_I,
    input wire ALU_CARRY_I,
    input wire ALU_OVF_I,
    // Program counter advance
    input wire PC_LOAD_I,
    input wire [`CRF_PC_W-1:0] PC_NEXT_I,
    // Addressing and status outputs
    output reg [`CRF_PC_W-1:0] PC_O,
    output reg [`CRF_PC_W-1:0] VECT_BASE_O,
    output reg [15:0] ACT_SP_O,
    output reg [15:0] STATIC_BASE_O,
    output reg [15:0] FRAME_BASE_O,
    output reg [31:0] ADDR_PAIR_O,
    output reg [`CRF_FLG_W-1:0] FLAGS_O
);

    // --------------------
    // Unbanked registers
    // --------------------
    reg [15:0] static_base_r;
    reg [`CRF_PC_W-1:0] vector_table_base_r;
    reg [`CRF_PC_W-1:0] program_counter_r;
    reg [15:0] user_stack_pointer_r;
    reg [15:0] irq_stack_pointer_r;
    reg [`CRF_FLG_W-1:0] status_flags_r;
    reg [`CRF_FLG_W-1:0] status_flags_nxt;

    // --------------------
    // Banked registers and the active view
    // --------------------
    wire [16*`CRF_BK_SLOTS-1:0] bank_regs [0:1];
    wire bank_sel = status_flags_r[`CRF_FLG_B];
    wire [16*`CRF_BK_SLOTS-1:0] act = bank_regs[bank_sel]; // [RQ16]
    wire [15:0] data_reg_0 = act[16*`CRF_BK_R0+15:16*`CRF_BK_R0];
    wire [15:0] data_reg_1 = act[16*`CRF_BK_R1+15:16*`CRF_BK_R1];
    wire [15:0] data_reg_2 = act[16*`CRF_BK_R2+15:16*`CRF_BK_R2];
    wire [15:0] data_reg_3 = act[16*`CRF_BK_R3+15:16*`CRF_BK_R3];
    wire [15:0] addr_reg_0 = act[16*`CRF_BK_A0+15:16*`CRF_BK_A0];
    wire [15:0] addr_reg_1 = act[16*`CRF_BK_A1+15:16*`CRF_BK_A1];
    wire [15:0] frame_base = act[16*`CRF_BK_FB+15:16*`CRF_BK_FB];
    // Stack-select flag picks the live pointer
    wire stack_sel = status_flags_r[`CRF_FLG_U];
    wire [15:0] active_stack_pointer = stack_sel ? user_stack_pointer_r
                                                 : irq_stack_pointer_r; // [RQ9]

    // --------------------
    // Read multiplexer, shared by both operand ports and the bus
    // --------------------
    function [31:0] rd_sel;
        input [4:0] sel;
        begin
            case (sel)
                `CRF_SEL_R0: rd_sel = {16'h0000, data_reg_0}; // [RQ1]
                `CRF_SEL_R1: rd_sel = {16'h0000, data_reg_1};
                `CRF_SEL_R2: rd_sel = {16'h0000, data_reg_2};
                `CRF_SEL_R3: rd_sel = {16'h0000, data_reg_3};
                `CRF_SEL_A0: rd_sel = {16'h0000, addr_reg_0}; // [RQ4]
                `CRF_SEL_A1: rd_sel = {16'h0000, addr_reg_1};
                `CRF_SEL_FB: rd_sel = {16'h0000, frame_base}; // [RQ6]
                `CRF_SEL_SB: rd_sel = {16'h0000, static_base_r}; // [RQ10]
                `CRF_SEL_VTB: rd_sel = {12'h000, vector_table_base_r}; // [RQ7]
                `CRF_SEL_PC: rd_sel = {12'h000, program_counter_r}; // [RQ8]
                `CRF_SEL_SP: rd_sel = {16'h0000, active_stack_pointer};
                `CRF_SEL_USP: rd_sel = {16'h0000, user_stack_pointer_r};
                `CRF_SEL_ISP: rd_sel = {16'h0000, irq_stack_pointer_r};
                `CRF_SEL_FLG: rd_sel = {21'h000000, status_flags_r}; // [RQ11]
                `CRF_SEL_R0L: rd_sel = {24'h000000, data_reg_0[7:0]}; // [RQ2]
                `CRF_SEL_R0H: rd_sel = {24'h000000, data_reg_0[15:8]};
                `CRF_SEL_R1L: rd_sel = {24'h000000, data_reg_1[7:0]};
                `CRF_SEL_R1H: rd_sel = {24'h000000, data_reg_1[15:8]};
                `CRF_SEL_PLO: rd_sel = {data_reg_2, data_reg_0}; // [RQ3]
                `CRF_SEL_PHI: rd_sel = {data_reg_3, data_reg_1};
                `CRF_SEL_APR: rd_sel = {addr_reg_1, addr_reg_0}; // [RQ5]
                default: rd_sel = 32'h00000000;
            endcase
        end
    endfunction

    // --------------------
    // APB handshake: one wait state; stalls while the core writes
    // --------------------
    wire [4:0] apb_sel = PADDR_I[`CRF_OFS_LSB+4:`CRF_OFS_LSB];
    wire apb_hole = (PADDR_I[`CRF_ADDR_W-1:`CRF_OFS_LSB+5] != 1'b0) ||
                    (PADDR_I[`CRF_OFS_LSB-1:0] != 2'h0) ||
                    (apb_sel > `CRF_SEL_LAST);
    // Core write has priority; bus waits rather than being dropped
    wire apb_go = PSEL_I && PENABLE_I && !PREADY_O && !EU_WE_I;
    wire apb_wr = apb_go && PWRITE_I && !apb_hole;

    always @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h00000000;
        end
        else
        begin
            PREADY_O <= apb_go;
            PSLVERR_O <= apb_go && apb_hole;
            if (apb_go && !PWRITE_I && !apb_hole)
                PRDATA_O <= rd_sel(apb_sel);
            else
                PRDATA_O <= 32'h00000000;
        end
    end

    // --------------------
    // Merged write request, core first, then bus
    // --------------------
    wire w_en = EU_WE_I || apb_wr;
    wire [4:0] w_sel = EU_WE_I ? EU_WSEL_I : apb_sel;
    wire [31:0] w_data = EU_WE_I ? EU_WDATA_I : PWDATA_I;

    // Bank port decode: low half on A, pair upper half on B
    reg wa_en;
    reg [2:0] wa_slot;
    reg [1:0] wa_be;
    reg [15:0] wa_data;
    reg wb_en;
    reg [2:0] wb_slot;

    always @*
    begin
        wa_en = w_en;
        wa_slot = `CRF_BK_R0;
        wa_be = 2'h3;
        wa_data = w_data[15:0];
        wb_en = 1'b0;
        wb_slot = `CRF_BK_R2;
        case (w_sel)
            `CRF_SEL_R0: wa_slot = `CRF_BK_R0; // [RQ1]
            `CRF_SEL_R1: wa_slot = `CRF_BK_R1;
            `CRF_SEL_R2: wa_slot = `CRF_BK_R2;
            `CRF_SEL_R3: wa_slot = `CRF_BK_R3;
            `CRF_SEL_A0: wa_slot = `CRF_BK_A0; // [RQ4]
            `CRF_SEL_A1: wa_slot = `CRF_BK_A1;
            `CRF_SEL_FB: wa_slot = `CRF_BK_FB; // [RQ6]
            `CRF_SEL_R0L:
            begin
                wa_slot = `CRF_BK_R0; // [RQ2]
                wa_be = 2'h1;
            end
            `CRF_SEL_R0H:
            begin
                wa_slot = `CRF_BK_R0; // [RQ2]
                wa_be = 2'h2;
                wa_data = {w_data[7:0], 8'h00};
            end
            `CRF_SEL_R1L:
            begin
                wa_slot = `CRF_BK_R1;
                wa_be = 2'h1;
            end
            `CRF_SEL_R1H:
            begin
                wa_slot = `CRF_BK_R1;
                wa_be = 2'h2;
                wa_data = {w_data[7:0], 8'h00};
            end
            `CRF_SEL_PLO:
            begin
                wa_slot = `CRF_BK_R0; // [RQ3]
                wb_en = w_en;
                wb_slot = `CRF_BK_R2;
            end
            `CRF_SEL_PHI:
            begin
                wa_slot = `CRF_BK_R1; // [RQ3]
                wb_en = w_en;
                wb_slot = `CRF_BK_R3;
            end
            `CRF_SEL_APR:
            begin
                wa_slot = `CRF_BK_A0; // [RQ5]
                wb_en = w_en;
                wb_slot = `CRF_BK_A1;
            end
            default: wa_en = 1'b0;
        endcase
    end

    // --------------------
    // Two banks; only the selected one sees writes
    // --------------------
    genvar b;
    generate
        for (b = 0; b < 2; b = b + 1)
        begin : bank
            crf_bank u_bank
            (
                .clk_i(REF_CLK_I),
                .rst_n_i(RST_N_I),
                .wa_en_i(wa_en && (bank_sel == b)), // [RQ18]
                .wa_slot_i(wa_slot),
                .wa_be_i(wa_be),
                .wa_data_i(wa_data),
                .wb_en_i(wb_en && (bank_sel == b)),
                .wb_slot_i(wb_slot),
                .wb_data_i(w_data[31:16]),
                .regs_o(bank_regs[b])
            );
        end
    endgenerate

    // --------------------
    // Unbanked pointer and base registers
    // --------------------
    always @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            static_base_r <= `CRF_RST_WORD;
            vector_table_base_r <= `CRF_RST_ADDR20;
            program_counter_r <= PC_RESET;
            user_stack_pointer_r <= `CRF_RST_WORD;
            irq_stack_pointer_r <= `CRF_RST_WORD;
        end
        else
        begin
            if (w_en && w_sel == `CRF_SEL_SB)
                static_base_r <= w_data[15:0]; // [RQ10] [RQ18]
            if (w_en && w_sel == `CRF_SEL_VTB)
                vector_table_base_r <= w_data[`CRF_PC_W-1:0]; // [RQ7]
            // Explicit write beats the sequential advance
            if (w_en && w_sel == `CRF_SEL_PC)
                program_counter_r <= w_data[`CRF_PC_W-1:0]; // [RQ8]
            else if (PC_LOAD_I)
                program_counter_r <= PC_NEXT_I; // [RQ8]
            if (w_en && (w_sel == `CRF_SEL_USP || (w_sel == `CRF_SEL_SP && stack_sel)))
                user_stack_pointer_r <= w_data[15:0]; // [RQ9]
            if (w_en && (w_sel == `CRF_SEL_ISP || (w_sel == `CRF_SEL_SP && !stack_sel)))
                irq_stack_pointer_r <= w_data[15:0]; // [RQ9]
        end
    end

    // --------------------
    // Status flags: ALU result sizes the zero and sign tests
    // --------------------
    reg res_zero;
    reg res_neg;

    always @*
    begin
        case (ALU_SIZE_I)
            `CRF_SIZE_BYTE:
            begin
                res_zero = (ALU_RESULT_I[7:0] == 8'h00);
                res_neg = ALU_RESULT_I[7];
            end
            `CRF_SIZE_WORD:
            begin
                res_zero = (ALU_RESULT_I[15:0] == 16'h0000);
                res_neg = ALU_RESULT_I[15];
            end
            default:
            begin
                res_zero = (ALU_RESULT_I == 32'h00000000);
                res_neg = ALU_RESULT_I[31];
            end
        endcase
    end

    // Register write replaces the word; ALU bits then override it
    always @*
    begin
        status_flags_nxt = status_flags_r;
        if (w_en && w_sel == `CRF_SEL_FLG)
            status_flags_nxt = w_data[`CRF_FLG_W-1:0] & `CRF_FLG_WMASK; // [RQ11]
        if (ALU_FLAG_WE_I)
        begin
            if (ALU_FMASK_I[0])
                status_flags_nxt[`CRF_FLG_C] = ALU_CARRY_I; // [RQ12]
            if (ALU_FMASK_I[1])
                status_flags_nxt[`CRF_FLG_Z] = res_zero; // [RQ14]
            if (ALU_FMASK_I[2])
                status_flags_nxt[`CRF_FLG_S] = res_neg; // [RQ15]
            if (ALU_FMASK_I[3])
                status_flags_nxt[`CRF_FLG_O] = ALU_OVF_I; // [RQ17]
        end
    end

    // Debug bit is stored as written; software must keep it clear
    always @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            status_flags_r <= `CRF_RST_FLG;
        else
            status_flags_r <= status_flags_nxt; // [RQ11]
    end

    // --------------------
    // Registered outputs, one cycle behind the selects and the state
    // --------------------
    always @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            EU_OPA_O <= 32'h00000000;
            EU_OPB_O <= 32'h00000000;
            PC_O <= `CRF_RST_ADDR20;
            VECT_BASE_O <= `CRF_RST_ADDR20;
            ACT_SP_O <= `CRF_RST_WORD;
            STATIC_BASE_O <= `CRF_RST_WORD;
            FRAME_BASE_O <= `CRF_RST_WORD;
            ADDR_PAIR_O <= 32'h00000000;
            FLAGS_O <= `CRF_RST_FLG;
        end
        else
        begin
            EU_OPA_O <= rd_sel(EU_RSEL_A_I); // [RQ1] [RQ4]
            EU_OPB_O <= rd_sel(EU_RSEL_B_I);
            PC_O <= program_counter_r; // [RQ8]
            VECT_BASE_O <= vector_table_base_r; // [RQ7]
            ACT_SP_O <= active_stack_pointer; // [RQ9]
            STATIC_BASE_O <= static_base_r; // [RQ10]
            FRAME_BASE_O <= frame_base; // [RQ6]
            ADDR_PAIR_O <= {addr_reg_1, addr_reg_0}; // [RQ4] [RQ5]
            FLAGS_O <= status_flags_r;
        end
    end

endmodule

// [shared/crf_defs.vh]
// Constants for the processor register file: selector codes, offsets, flag bits, resets
`ifndef CRF_DEFS_VH
`define CRF_DEFS_VH

// --------------------
// Register selector codes (shared by execution port and bus)
// --------------------
`define CRF_SEL_R0 5'h00
`define CRF_SEL_R1 5'h01
`define CRF_SEL_R2 5'h02
`define CRF_SEL_R3 5'h03
`define CRF_SEL_A0 5'h04
`define CRF_SEL_A1 5'h05
`define CRF_SEL_FB 5'h06
`define CRF_SEL_SB 5'h07
`define CRF_SEL_VTB 5'h08
`define CRF_SEL_PC 5'h09
`define CRF_SEL_SP 5'h0A
`define CRF_SEL_USP 5'h0B
`define CRF_SEL_ISP 5'h0C
`define CRF_SEL_FLG 5'h0D
`define CRF_SEL_R0L 5'h0E
`define CRF_SEL_R0H 5'h0F
`define CRF_SEL_R1L 5'h10
`define CRF_SEL_R1H 5'h11
`define CRF_SEL_PLO 5'h12
`define CRF_SEL_PHI 5'h13
`define CRF_SEL_APR 5'h14
`define CRF_SEL_LAST 5'h14

// --------------------
// Bus map: byte address is selector code times four
// --------------------
`define CRF_ADDR_W 8
`define CRF_OFS_LSB 2

// --------------------
// Slots inside one register bank
// --------------------
`define CRF_BK_R0 3'h0
`define CRF_BK_R1 3'h1
`define CRF_BK_R2 3'h2
`define CRF_BK_R3 3'h3
`define CRF_BK_A0 3'h4
`define CRF_BK_A1 3'h5
`define CRF_BK_FB 3'h6
`define CRF_BK_SLOTS 7

// --------------------
// Status flag positions and width
// --------------------
`define CRF_FLG_W 11
`define CRF_FLG_C 0
`define CRF_FLG_D 1
`define CRF_FLG_Z 2
`define CRF_FLG_S 3
`define CRF_FLG_B 4
`define CRF_FLG_O 5
`define CRF_FLG_U 7
`define CRF_FLG_WMASK 11'h0BF

// --------------------
// Widths, operand sizes and reset values
// --------------------
`define CRF_PC_W 20
`define CRF_SIZE_BYTE 2'h0
`define CRF_SIZE_WORD 2'h1
`define CRF_SIZE_LONG 2'h2
`define CRF_RST_WORD 16'h0000
`define CRF_RST_ADDR20 20'h00000
`define CRF_RST_FLG 11'h000

`endif

// [hw/crf_bank.v]
// One register bank: four data, two address and the frame base register
`timescale 1ns/1ns
`include "crf_defs.vh"

module crf_bank
(
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Port A: word or byte-lane write
    input wire wa_en_i,
    input wire [2:0] wa_slot_i,
    input wire [1:0] wa_be_i,
    input wire [15:0] wa_data_i,
    // Port B: full word write, used for the upper half of pairs
    input wire wb_en_i,
    input wire [2:0] wb_slot_i,
    input wire [15:0] wb_data_i,
    // All slots, slot n in bits [16n+15:16n]
    output wire [16*`CRF_BK_SLOTS-1:0] regs_o
);

    genvar g;

    // --------------------
    // Storage, one flop word per slot
    // --------------------
    generate
        for (g = 0; g < `CRF_BK_SLOTS; g = g + 1)
        begin : slot
            reg [15:0] word_r;
            wire hit_a = wa_en_i && (wa_slot_i == g);
            wire hit_b = wb_en_i && (wb_slot_i == g);

            // Byte lanes leave the other half untouched [RQ2]
            always @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    word_r <= `CRF_RST_WORD;
                else if (hit_a)
                begin
                    if (wa_be_i[0])
                        word_r[7:0] <= wa_data_i[7:0];
                    if (wa_be_i[1])
                        word_r[15:8] <= wa_data_i[15:8];
                end
                else if (hit_b)
                    word_r <= wb_data_i;
            end

            assign regs_o[16*g+15:16*g] = word_r;
        end
    endgenerate

endmodule

// [verif/crf_properties.sv]
// Concurrent checks on the register file top-level ports
`timescale 1ns/1ns

module crf_props
(
    // Clock, reset and bus
    input wire REF_CLK_I,
    input wire RST_N_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [7:0] PADDR_I,
    input wire [31:0] PRDATA_O,
    input wire PREADY_O,
    input wire PSLVERR_O,
    // Execution unit, ALU and status
    input wire EU_WE_I,
    input wire ALU_FLAG_WE_I,
    input wire [3:0] ALU_FMASK_I,
    input wire [1:0] ALU_SIZE_I,
    input wire [31:0] ALU_RESULT_I,
    input wire ALU_CARRY_I,
    input wire ALU_OVF_I,
    input wire PC_LOAD_I,
    input wire [19:0] PC_NEXT_I,
    input wire [19:0] PC_O,
    input wire [10:0] FLAGS_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    // Waiting access; refused address
    wire acc = PSEL_I && PENABLE_I && !PREADY_O;
    wire bad = (PADDR_I > 8'h50) || (PADDR_I[1:0] != 2'h0);

    a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready stuck");
    a_ready_delay: assert property (acc && !EU_WE_I |=> PREADY_O)
        else $error("no ready");
    a_eu_priority: assert property (acc && EU_WE_I |=> !PREADY_O)
        else $error("ready during core write");
    a_bad_refused: assert property (PREADY_O && bad |-> PSLVERR_O)
        else $error("no refusal");
    a_good_taken: assert property (PREADY_O && !bad |-> !PSLVERR_O)
        else $error("false refusal");
    a_rdata_idle: assert property (!(PREADY_O && !PWRITE_I && !PSLVERR_O)
        |-> PRDATA_O == 32'h0) else $error("read data not zero");
    a_carry_flag: assert property (ALU_FLAG_WE_I && ALU_FMASK_I[0]
        |-> ##2 FLAGS_O[0] == $past(ALU_CARRY_I, 2)) else $error("carry flag wrong");
    a_zero_word: assert property (ALU_FLAG_WE_I && ALU_FMASK_I[1] && ALU_SIZE_I == 2'h1
        |-> ##2 FLAGS_O[2] == ($past(ALU_RESULT_I[15:0], 2) == 16'h0)) else $error("zero flag wrong");
    a_sign_byte: assert property (ALU_FLAG_WE_I && ALU_FMASK_I[2] && ALU_SIZE_I == 2'h0
        |-> ##2 FLAGS_O[3] == $past(ALU_RESULT_I[7], 2)) else $error("sign flag wrong");
    a_ovf_flag: assert property (ALU_FLAG_WE_I && ALU_FMASK_I[3]
        |-> ##2 FLAGS_O[5] == $past(ALU_OVF_I, 2)) else $error("overflow flag wrong");
    a_pc_load: assert property (PC_LOAD_I && !EU_WE_I && !(acc && PWRITE_I)
        |-> ##2 PC_O == $past(PC_NEXT_I, 2)) else $error("pc load lost");
    a_flag_width: assert property (FLAGS_O[10:8] == 3'h0 && !FLAGS_O[6])
        else $error("spare flag set");

    // Main scenarios reached
    c_refused: cover property (PREADY_O && PSLVERR_O);
    c_read_ok: cover property (PREADY_O && !PWRITE_I && !PSLVERR_O);
    c_eu_wait: cover property (acc && EU_WE_I);
endmodule

bind crf_top crf_props i_props (.*);

// [verif/crf_eu_model.sv]
// Execution unit and ALU stand-in driving the register file
`timescale 1ns/1ns

module crf_eu_model
(
    // Clock
    input wire clk_i,
    // Register write
    output logic we_o,
    output logic [4:0] wsel_o,
    output logic [31:0] wdata_o,
    // Flag update and program counter load
    output logic fwe_o,
    output logic [3:0] fmask_o,
    output logic [1:0] size_o,
    output logic [31:0] res_o,
    output logic carry_o,
    output logic ovf_o,
    output logic pcld_o,
    output logic [19:0] pcnx_o
);
    // Quiet until a task is called
    initial
    begin
        {we_o, wsel_o, wdata_o, fwe_o, fmask_o, size_o} = '0;
        {res_o, carry_o, ovf_o, pcld_o, pcnx_o} = '0;
    end

    // One-cycle write; flag writes always keep the debug bit clear
    task eu_wr(input [4:0] s, input [31:0] d);
    begin
        @(posedge clk_i);
        {we_o, wsel_o} <= {1'b1, s};
        wdata_o <= (s == 5'h0D) ? (d & 32'hFFFFFFFD) : d;
        @(posedge clk_i);
        we_o <= 1'b0;
    end
    endtask

    // One ALU result with all four flag enables
    task alu(input [1:0] z, input [31:0] r, input c, input o);
    begin
        @(posedge clk_i);
        {fwe_o, fmask_o, size_o, res_o, carry_o, ovf_o} <= {1'b1, 4'hF, z, r, c, o};
        @(posedge clk_i);
        fwe_o <= 1'b0;
    end
    endtask

    // Program counter advance
    task pc_ld(input [19:0] p);
    begin
        @(posedge clk_i);
        {pcld_o, pcnx_o} <= {1'b1, p};
        @(posedge clk_i);
        pcld_o <= 1'b0;
    end
    endtask
endmodule

// [verif/test_cpu_register_file.sv]
// Self-checking bench for the processor register file
`timescale 1ns/1ns
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin fails++; \
    $display("BAD %0t got %h exp %h", $time, g, x); end end

module test_cpu_register_file;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [4:0] rsa = 5'h00;
    logic [4:0] rsb = 5'h00;
    logic [31:0] prdata, opa, opb, apair, wdata, res, q, d;
    logic pready, pslverr, we, fwe, carry, ovf, pcld, e, zf, sf;
    logic [4:0] wsel;
    logic [3:0] fmask;
    logic [1:0] size;
    logic [19:0] pcnx, pc, vtb;
    logic [15:0] sp, sb, fb;
    logic [10:0] status_flags;
    logic [31:0] expv [0:12];
    logic [7:0] badad [0:2] = '{8'h54, 8'h01, 8'h80};
    int fails = 0;
    int compares = 0;
    int i, k;

    // Clock: 20 ns period
    always #10 clk = ~clk;

    crf_eu_model i_eu (.clk_i(clk), .we_o(we), .wsel_o(wsel), .wdata_o(wdata), .fwe_o(fwe),
        .fmask_o(fmask), .size_o(size), .res_o(res), .carry_o(carry), .ovf_o(ovf),
        .pcld_o(pcld), .pcnx_o(pcnx));

    crf_top i_dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .EU_RSEL_A_I(rsa), .EU_RSEL_B_I(rsb),
        .EU_OPA_O(opa), .EU_OPB_O(opb), .EU_WE_I(we), .EU_WSEL_I(wsel), .EU_WDATA_I(wdata),
        .ALU_FLAG_WE_I(fwe), .ALU_FMASK_I(fmask), .ALU_SIZE_I(size), .ALU_RESULT_I(res),
        .ALU_CARRY_I(carry), .ALU_OVF_I(ovf), .PC_LOAD_I(pcld), .PC_NEXT_I(pcnx), .PC_O(pc),
        .VECT_BASE_O(vtb), .ACT_SP_O(sp), .STATIC_BASE_O(sb), .FRAME_BASE_O(fb),
        .ADDR_PAIR_O(apair), .FLAGS_O(status_flags));

    // Register width: 20 bits for vector base and program counter
    function automatic [31:0] wmask(input int c);
        return (c == 8 || c == 9) ? 32'h000FFFFF : 32'h0000FFFF;
    endfunction

    task give_verdict;
    begin
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask

    // Bus transfer; request held until ready is sampled high
    task apb(input w, input [7:0] a, input [31:0] dd);
        int n;
    begin
        @(posedge clk);
        {psel, pwr, paddr, pwdata} <= {1'b1, w, a, dd};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        for (n = 0; n < 40 && pready !== 1'b1; n++)
            @(posedge clk);
        if (pready !== 1'b1)
        begin
            fails++;
            $display("BAD %0t bus timeout", $time);
            give_verdict();
        end
        {q, e} = {prdata, pslverr};
        {psel, pen} <= 2'b00;
    end
    endtask

    task wr(input [4:0] c, input [31:0] dd);
        apb(1'b1, {1'b0, c, 2'b00}, dd);
    endtask

    task rd(input [4:0] c, input [31:0] x);
    begin
        apb(1'b0, {1'b0, c, 2'b00}, 32'h0);
        `CHK(q, x)
        `CHK(e, 1'b0)
    end
    endtask

    // Outputs lag internal state by one cycle
    task settle;
    begin
        repeat (2) @(posedge clk);
        @(negedge clk);
    end
    endtask

    // Main sequence
    initial
    begin
        k = $urandom(32'h0C1A);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i <= 20; i++)
            rd(i[4:0], 32'h0);
        for (i = 0; i <= 12; i++)
        begin
            d = $urandom;
            expv[i] = d & wmask(i);
            if (i != 10)
                wr(i[4:0], d);
        end
        expv[10] = expv[12];
        for (i = 0; i <= 12; i++)
            rd(i[4:0], expv[i]);
        settle();
        `CHK(pc, expv[9][19:0])
        `CHK(vtb, expv[8][19:0])
        `CHK(sb, expv[7][15:0])
        `CHK(fb, expv[6][15:0])
        `CHK(sp, expv[12][15:0])
        for (k = 0; k < 2; k++)
        begin
            i = 14 + 2 * k;
            d = $urandom;
            wr(i[4:0], d);
            expv[k][7:0] = d[7:0];
            d = $urandom;
            wr(i[4:0] + 5'h01, d);
            expv[k][15:8] = d[7:0];
            rd(k[4:0], expv[k]);
            rd(i[4:0], {24'h0, expv[k][7:0]});
            rd(i[4:0] + 5'h01, {24'h0, expv[k][15:8]});
        end
        // Pairs: later register is the upper half
        for (k = 0; k < 3; k++)
        begin
            i = 18 + k;
            d = $urandom;
            wr(i[4:0], d);
            expv[k == 2 ? 4 : k] = {16'h0, d[15:0]};
            expv[k == 2 ? 5 : k + 2] = {16'h0, d[31:16]};
            rd(k == 2 ? 5'h04 : k[4:0], {16'h0, d[15:0]});
            rd(k == 2 ? 5'h05 : k[4:0] + 5'h02, {16'h0, d[31:16]});
            rd(i[4:0], d);
        end
        settle();
        `CHK(apair, {expv[5][15:0], expv[4][15:0]})
        // Flag register: writable bits only, debug bit kept clear
        wr(5'h0D, 32'hFFFFFFFD);
        rd(5'h0D, 32'h000000BD);
        wr(5'h0D, 32'h00000010);
        rd(5'h00, 32'h0);
        rd(5'h06, 32'h0);
        rd(5'h07, expv[7]);
        d = $urandom;
        wr(5'h00, d);
        rd(5'h00, {16'h0, d[15:0]});
        wr(5'h0D, 32'h00000080);
        rd(5'h00, expv[0]);
        settle();
        `CHK(fb, expv[6][15:0])
        `CHK(sp, expv[11][15:0])
        d = $urandom;
        wr(5'h0A, d);
        rd(5'h0B, {16'h0, d[15:0]});
        wr(5'h0D, 32'h0);
        rd(5'h0A, expv[12]);
        // Refused addresses leave state alone
        for (k = 0; k < 3; k++)
        begin
            apb(1'b1, badad[k], $urandom);
            `CHK(e, 1'b1)
            apb(1'b0, badad[k], 32'h0);
            `CHK({e, q}, {1'b1, 32'h0})
        end
        rd(5'h00, expv[0]);
        // ALU results, corners first: zero, negative, zero only in low lanes
        for (k = 0; k < 24; k++)
        begin
            d = (k < 4) ? 32'h0 : (k < 8) ? 32'h80008080 : (k < 12) ? 32'h00010000 : $urandom;
            q = $urandom;
            i_eu.alu(k[1:0], d, q[0], q[1]);
            zf = (k[1:0] == 2'h0) ? (d[7:0] == 8'h00) : (k[1:0] == 2'h1) ? (d[15:0] == 16'h0)
                : (d == 32'h0);
            sf = (k[1:0] == 2'h0) ? d[7] : (k[1:0] == 2'h1) ? d[15] : d[31];
            settle();
            `CHK(status_flags, {5'h00, q[1], 1'b0, sf, zf, 1'b0, q[0]})
        end
        // Execution write during a bus read; bus waits, then operands
        d = $urandom;
        fork
            apb(1'b0, 8'h00, 32'h0);
            begin
                @(posedge clk);
                i_eu.eu_wr(5'h02, d);
            end
        join
        `CHK(q, expv[0])
        rsa <= 5'h04;
        rsb <= 5'h12;
        settle();
        `CHK(opa, expv[4])
        `CHK(opb, {d[15:0], expv[0][15:0]})
        d = $urandom;
        i_eu.pc_ld(d[19:0]);
        settle();
        `CHK(pc, d[19:0])
        give_verdict();
    end
endmodule
